// ### sdi_pkg.sv
// constants, register map and carrier types of the status indicator block
`default_nettype none
package sdi_pkg;
    // ********************************************************************
    // clock and timing
    // ********************************************************************
    localparam int CLK_HZ = 10_000_000;
    localparam int TICK_MS = 10;
    localparam int TICK_CYC_DEF = CLK_HZ / 1000 * TICK_MS;
    localparam int HOLD_MS = 5000;
    localparam int DEB_MS = 20;
    localparam int FLASH_MS = 500;
    localparam int GAP_MS = 300;
    localparam int PAUSE_MS = 2000;
    localparam int HB_MS = 500;
    localparam int BLINK_MS = 250;
    localparam logic [9:0] HOLD_T = 10'(HOLD_MS / TICK_MS);
    localparam logic [9:0] DEB_T = 10'(DEB_MS / TICK_MS);
    localparam logic [9:0] FLASH_T = 10'(FLASH_MS / TICK_MS);
    localparam logic [9:0] GAP_T = 10'(GAP_MS / TICK_MS);
    localparam logic [9:0] PAUSE_T = 10'(PAUSE_MS / TICK_MS);
    localparam logic [9:0] HB_T = 10'(HB_MS / TICK_MS);
    localparam logic [9:0] BLINK_T = 10'(BLINK_MS / TICK_MS);
    // ********************************************************************
    // register offsets (byte addresses)
    // ********************************************************************
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_WCOND = 8'h04;
    localparam logic [7:0] A_WLATCH = 8'h08;
    localparam logic [7:0] A_FCODE = 8'h0C;
    localparam logic [7:0] A_LSMAP = 8'h10;
    localparam logic [7:0] A_ISTAT = 8'h14;
    localparam logic [7:0] A_IMASK = 8'h18;
    localparam logic [7:0] A_STATUS = 8'h1C;
    // ctrl and fcode field positions
    localparam int C_UTIL = 0;
    localparam int C_GEN = 1;
    localparam int C_AUTO = 2;
    localparam int C_SYNCING = 3;
    localparam int C_SYNCED = 4;
    localparam int C_FAIL = 5;
    localparam int C_SYNCOK = 6;
    localparam int C_CODE = 8;
    localparam int F_CNT = 16;
    // interrupt bit positions
    localparam int I_ENTER = 0;
    localparam int I_EXIT = 1;
    localparam int I_RESET = 2;
    localparam int I_WARN = 3;
    // reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] ZERO32 = 32'h0000_0000;
    // ********************************************************************
    // system state codes and glyphs (gfedcba)
    // ********************************************************************
    localparam logic [2:0] ST_NOTAV = 3'h0;
    localparam logic [2:0] ST_SYNC = 3'h1;
    localparam logic [2:0] ST_OK = 3'h2;
    localparam logic [2:0] ST_MAN = 3'h3;
    localparam logic [2:0] ST_STBY = 3'h4;
    localparam logic [6:0] G_DASH = 7'h40;
    localparam logic [6:0] G_SIX = 7'h7D;
    localparam logic [6:0] G_SEVEN = 7'h07;
    localparam logic [6:0] G_C = 7'h39;
    localparam logic [6:0] G_J = 7'h1E;
    localparam logic [6:0] G_OFF = 7'h00;
    // ********************************************************************
    // carriers
    // ********************************************************************
    typedef struct packed {
        logic dp;
        logic [6:0] seg;
    } sdi_disp_t;
    typedef struct packed {
        logic util_avail;
        logic genset_avail;
        logic not_auto;
        logic common_warning;
        logic heartbeat;
        logic sync_green;
        logic sync_red;
    } sdi_lamps_t;
endpackage
`default_nettype wire

// ### sdi_status_indicator.sv
// front-panel lamps, state digit and fault reset logic with wishbone regs
// ****************************************************************************
// Summary of operation
// - lamps show availability, auto, common warning
// - heartbeat lamp blinks while running
// - sync lamp blinks, steady green, or red
// - reset gives state mode, point dark
// - state glyphs dash, 6, 7, C, J
// - five second hold enters diagnostic mode
// - decimal point lit during diagnostic mode
// - flash code digits with gaps, long pause
// - warnings latch until fault reset
// - latched warnings mapped onto low-side drivers
// - five second hold leaves diagnostic mode
// - short press outside diagnostics clears corrected
// - sync flashing needs enable and both sources
// - availability relays follow availability lamps
// - sync check passed output
// ****************************************************************************
`default_nettype none
module sdi_status_indicator #(
    parameter int TICK_CYC = sdi_pkg::TICK_CYC_DEF
) (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic irq_o,
    // panel pins
    input wire logic fault_reset_switch_in,
    input wire logic sync_enable_in,
    output sdi_pkg::sdi_lamps_t lamps_o,
    output sdi_pkg::sdi_disp_t state_digit_display,
    output logic util_relay_o,
    output logic gen_relay_o,
    output logic sync_ok_o,
    output logic [7:0] low_side_o
);
    // all assertions share the one clock and the synchronous reset
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // ************************************************************************
    // helpers
    // ************************************************************************
    // byte-lane write merge
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        return (old & ~m) | (nw & m);
    endfunction

    // bcd digit to segments
    function automatic logic [6:0] digit_seg(input logic [3:0] d);
        case (d)
            4'h0: digit_seg = 7'h3F;
            4'h1: digit_seg = 7'h06;
            4'h2: digit_seg = 7'h5B;
            4'h3: digit_seg = 7'h4F;
            4'h4: digit_seg = 7'h66;
            4'h5: digit_seg = 7'h6D;
            4'h6: digit_seg = 7'h7D;
            4'h7: digit_seg = 7'h07;
            4'h8: digit_seg = 7'h7F;
            4'h9: digit_seg = 7'h6F;
            default: digit_seg = sdi_pkg::G_DASH;
        endcase
    endfunction

    // ************************************************************************
    // time base
    // ************************************************************************
    logic [16:0] tick_cnt_r;
    logic tick;
    assign tick = ce_i && (tick_cnt_r == 17'(TICK_CYC - 1));

    // free-running tick divider
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_cnt_r <= 17'h0_0000;
        end else if (ce_i) begin
            tick_cnt_r <= tick ? 17'h0_0000 : tick_cnt_r + 17'h0_0001;
        end
    end

    // ************************************************************************
    // pin synchronisers and switch debounce
    // ************************************************************************
    logic [1:0] sw_sync_r;
    logic [1:0] en_sync_r;
    logic sw_r;
    logic [9:0] deb_cnt_r;

    // two-flop synchronisers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sw_sync_r <= 2'h0;
            en_sync_r <= 2'h0;
        end else if (ce_i) begin
            sw_sync_r <= {sw_sync_r[0], fault_reset_switch_in};
            en_sync_r <= {en_sync_r[0], sync_enable_in};
        end
    end

    // level accepted after staying changed for the debounce time
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sw_r <= 1'b0;
            deb_cnt_r <= 10'h000;
        end else if (ce_i) begin
            if (sw_sync_r[1] == sw_r) begin
                deb_cnt_r <= 10'h000;
            end else if (tick) begin
                if (deb_cnt_r == sdi_pkg::DEB_T - 10'h001) begin
                    sw_r <= sw_sync_r[1];
                    deb_cnt_r <= 10'h000;
                end else begin
                    deb_cnt_r <= deb_cnt_r + 10'h001;
                end
            end
        end
    end

    // ************************************************************************
    // press timing and mode
    // ************************************************************************
    logic [9:0] press_r;
    logic long_done_r;
    logic diag_r;
    logic sw_d_r;
    logic long_hit;
    logic fr_pulse;
    assign long_hit = tick && sw_r && !long_done_r &&
                      (press_r == sdi_pkg::HOLD_T - 10'h001);
    assign fr_pulse = ce_i && sw_d_r && !sw_r && !long_done_r && !diag_r;

    // press length counter, stops at HOLD_T - 1 once the hold time is reached
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            press_r <= 10'h000;
            long_done_r <= 1'b0;
            sw_d_r <= 1'b0;
        end else if (ce_i) begin
            sw_d_r <= sw_r;
            if (!sw_r) begin
                press_r <= 10'h000;
                long_done_r <= 1'b0;
            end else if (long_hit) begin
                long_done_r <= 1'b1;
            end else if (tick && !long_done_r) begin
                press_r <= press_r + 10'h001;
            end
        end
    end

    // long hold toggles between state and diagnostic mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            diag_r <= 1'b0;
        end else if (ce_i && long_hit) begin
            diag_r <= !diag_r;
        end
    end

    // ************************************************************************
    // wishbone registers
    // ************************************************************************
    logic [31:0] ctrl_r;
    logic [7:0] wcond_r;
    logic [7:0] wlatch_r;
    logic [17:0] fcode_r;
    logic [7:0] lsmap_r;
    logic [3:0] istat_r;
    logic [3:0] imask_r;
    logic ack_r;
    logic [31:0] rdat_r;
    logic acc;
    logic wr;
    logic [3:0] ev;
    logic [31:0] rd_mux;
    assign acc = ce_i && cyc_i && stb_i && !ack_r;
    assign wr = acc && we_i;

    // writable registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= sdi_pkg::CTRL_RST;
            wcond_r <= 8'h00;
            fcode_r <= 18'h0_0000;
            lsmap_r <= 8'h00;
            imask_r <= 4'h0;
        end else if (wr) begin
            case (adr_i)
                sdi_pkg::A_CTRL: ctrl_r <= merge(ctrl_r, dat_i, sel_i);
                sdi_pkg::A_WCOND:
                    wcond_r <=
                        8'(merge({24'h00_0000, wcond_r}, dat_i, sel_i));
                sdi_pkg::A_FCODE:
                    fcode_r <=
                        18'(merge({14'h0000, fcode_r}, dat_i, sel_i));
                sdi_pkg::A_LSMAP:
                    lsmap_r <=
                        8'(merge({24'h00_0000, lsmap_r}, dat_i, sel_i));
                sdi_pkg::A_IMASK:
                    imask_r <=
                        4'(merge({28'h000_0000, imask_r}, dat_i, sel_i));
                default: ;
            endcase
        end
    end

    // read mux, unmapped addresses read zero
    always_comb begin
        case (adr_i)
            sdi_pkg::A_CTRL: rd_mux = ctrl_r;
            sdi_pkg::A_WCOND: rd_mux = {24'h00_0000, wcond_r};
            sdi_pkg::A_WLATCH: rd_mux = {24'h00_0000, wlatch_r};
            sdi_pkg::A_FCODE: rd_mux = {14'h0000, fcode_r};
            sdi_pkg::A_LSMAP: rd_mux = {24'h00_0000, lsmap_r};
            sdi_pkg::A_ISTAT: rd_mux = {28'h000_0000, istat_r};
            sdi_pkg::A_IMASK: rd_mux = {28'h000_0000, imask_r};
            sdi_pkg::A_STATUS:
                rd_mux = {29'h0000_0000, en_sync_r[1], sw_r, diag_r};
            default: rd_mux = sdi_pkg::ZERO32;
        endcase
    end

    // one-cycle ack with registered read data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            rdat_r <= sdi_pkg::ZERO32;
        end else if (ce_i) begin
            ack_r <= acc;
            if (acc && !we_i) begin
                rdat_r <= rd_mux;
            end
        end
    end
    assign ack_o = ack_r;
    assign dat_o = rdat_r;

    // ************************************************************************
    // warning latch and interrupts
    // ************************************************************************
    // latched warnings hold until a fault reset drops corrected ones
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wlatch_r <= 8'h00;
        end else if (ce_i) begin
            if (fr_pulse) begin
                wlatch_r <= wcond_r;
            end else begin
                wlatch_r <= wlatch_r | wcond_r;
            end
        end
    end

    assign ev[sdi_pkg::I_ENTER] = long_hit && !diag_r;
    assign ev[sdi_pkg::I_EXIT] = long_hit && diag_r;
    assign ev[sdi_pkg::I_RESET] = fr_pulse;
    assign ev[sdi_pkg::I_WARN] = ce_i && ((wcond_r & ~wlatch_r) != 8'h00);

    // sticky status, read clears, new event wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            istat_r <= 4'h0;
        end else if (ce_i) begin
            if (acc && !we_i && adr_i == sdi_pkg::A_ISTAT) begin
                istat_r <= ev;
            end else begin
                istat_r <= istat_r | ev;
            end
        end
    end
    assign irq_o = (istat_r & imask_r) != 4'h0;

    // ************************************************************************
    // diagnostic code flasher
    // ************************************************************************
    typedef enum logic [3:0] {
        FL_IDLE = 4'b0001,
        FL_ON = 4'b0010,
        FL_GAP = 4'b0100,
        FL_PAUSE = 4'b1000
    } sdi_fl_t;
    sdi_fl_t fl_r;
    logic [9:0] fl_cnt_r;
    logic [1:0] dig_r;
    logic fl_end;
    logic [3:0] cur_dig;
    assign fl_end = tick && (fl_cnt_r == 10'h000);
    assign cur_dig = fcode_r[{dig_r, 2'b00} +: 4];

    // one digit on, short gap, long pause after the last
    always_ff @(posedge clk_i) begin
        if (rst_i || (ce_i && !diag_r)) begin
            fl_r <= FL_IDLE;
            fl_cnt_r <= 10'h000;
            dig_r <= 2'h0;
        end else if (ce_i) begin
            if (tick && fl_cnt_r != 10'h000) begin
                fl_cnt_r <= fl_cnt_r - 10'h001;
            end
            case (fl_r)
                FL_IDLE: begin
                    fl_r <= FL_ON;
                    dig_r <= 2'h0;
                    fl_cnt_r <= sdi_pkg::FLASH_T - 10'h001;
                end
                FL_ON: if (fl_end) begin
                    if (dig_r == fcode_r[sdi_pkg::F_CNT +: 2]) begin
                        fl_r <= FL_PAUSE;
                        fl_cnt_r <= sdi_pkg::PAUSE_T - 10'h001;
                    end else begin
                        fl_r <= FL_GAP;
                        fl_cnt_r <= sdi_pkg::GAP_T - 10'h001;
                    end
                end
                FL_GAP: if (fl_end) begin
                    fl_r <= FL_ON;
                    dig_r <= dig_r + 2'h1;
                    fl_cnt_r <= sdi_pkg::FLASH_T - 10'h001;
                end
                FL_PAUSE: if (fl_end) begin
                    fl_r <= FL_ON;
                    dig_r <= 2'h0;
                    fl_cnt_r <= sdi_pkg::FLASH_T - 10'h001;
                end
                default: fl_r <= FL_IDLE;
            endcase
        end
    end

    // ************************************************************************
    // display, blinkers and lamps
    // ************************************************************************
    logic [6:0] state_glyph;
    logic [9:0] hb_cnt_r;
    logic [9:0] bl_cnt_r;
    logic hb_r;
    logic bl_r;
    logic sync_flash;
    logic ut;
    logic gn;

    // system state glyph
    always_comb begin
        case (ctrl_r[sdi_pkg::C_CODE +: 3])
            sdi_pkg::ST_SYNC: state_glyph = sdi_pkg::G_SIX;
            sdi_pkg::ST_OK: state_glyph = sdi_pkg::G_SEVEN;
            sdi_pkg::ST_MAN: state_glyph = sdi_pkg::G_C;
            sdi_pkg::ST_STBY: state_glyph = sdi_pkg::G_J;
            default: state_glyph = sdi_pkg::G_DASH;
        endcase
    end

    // registered digit and point
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_digit_display <= '{dp: 1'b0, seg: sdi_pkg::G_DASH};
        end else if (ce_i) begin
            state_digit_display.dp <= diag_r;
            if (!diag_r) begin
                state_digit_display.seg <= state_glyph;
            end else if (fl_r == FL_ON) begin
                state_digit_display.seg <= digit_seg(cur_dig);
            end else begin
                state_digit_display.seg <= sdi_pkg::G_OFF;
            end
        end
    end

    // heartbeat and sync blink generators
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hb_cnt_r <= 10'h000;
            bl_cnt_r <= 10'h000;
            hb_r <= 1'b0;
            bl_r <= 1'b0;
        end else if (tick) begin
            if (hb_cnt_r == sdi_pkg::HB_T - 10'h001) begin
                hb_cnt_r <= 10'h000;
                hb_r <= !hb_r;
            end else begin
                hb_cnt_r <= hb_cnt_r + 10'h001;
            end
            if (bl_cnt_r == sdi_pkg::BLINK_T - 10'h001) begin
                bl_cnt_r <= 10'h000;
                bl_r <= !bl_r;
            end else begin
                bl_cnt_r <= bl_cnt_r + 10'h001;
            end
        end
    end

    assign ut = ctrl_r[sdi_pkg::C_UTIL];
    assign gn = ctrl_r[sdi_pkg::C_GEN];
    assign sync_flash = en_sync_r[1] && ut && gn &&
                        ctrl_r[sdi_pkg::C_SYNCING];

    // registered lamps and drivers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lamps_o <= '0;
            util_relay_o <= 1'b0;
            gen_relay_o <= 1'b0;
            sync_ok_o <= 1'b0;
            low_side_o <= 8'h00;
        end else if (ce_i) begin
            lamps_o.util_avail <= ut;
            lamps_o.genset_avail <= gn;
            lamps_o.not_auto <= !ctrl_r[sdi_pkg::C_AUTO];
            lamps_o.common_warning <= wlatch_r != 8'h00;
            lamps_o.heartbeat <= hb_r;
            lamps_o.sync_red <= ctrl_r[sdi_pkg::C_FAIL];
            if (ctrl_r[sdi_pkg::C_FAIL]) begin
                lamps_o.sync_green <= 1'b0;
            end else if (ctrl_r[sdi_pkg::C_SYNCED]) begin
                lamps_o.sync_green <= 1'b1;
            end else begin
                lamps_o.sync_green <= sync_flash && bl_r;
            end
            util_relay_o <= ut;
            gen_relay_o <= gn;
            sync_ok_o <= ctrl_r[sdi_pkg::C_SYNCOK];
            low_side_o <= wlatch_r & lsmap_r;
        end
    end

    // ************************************************************************
    // assertions
    // ************************************************************************
    sequence hold_reached;
        long_hit ##1 1'b1;
    endsequence

    dp_follows_mode_a: assert property (
        ce_i |=> state_digit_display.dp == $past(diag_r))
        else $error("decimal point not following mode");
    mode_toggle_a: assert property (
        hold_reached |-> diag_r != $past(diag_r))
        else $error("long hold did not toggle mode");
    mode_stable_a: assert property (
        !long_hit |=> diag_r == $past(diag_r))
        else $error("mode changed without long hold");
    reset_only_state_a: assert property (
        fr_pulse |-> !diag_r && $past(sw_r) && !sw_r)
        else $error("fault reset outside short press");
    warn_hold_a: assert property (
        (ce_i && !fr_pulse) |=> ($past(wlatch_r) & ~wlatch_r) == 8'h00)
        else $error("latched warning lost");
    warn_clear_a: assert property (
        fr_pulse |=> wlatch_r == $past(wcond_r))
        else $error("fault reset did not drop corrected warnings");
    glyph_six_a: assert property (
        (ce_i && !diag_r &&
         ctrl_r[sdi_pkg::C_CODE +: 3] == sdi_pkg::ST_SYNC)
        |=> state_digit_display.seg == sdi_pkg::G_SIX)
        else $error("synchronizing glyph wrong");
    synced_steady_a: assert property (
        (ce_i && ctrl_r[sdi_pkg::C_SYNCED] && !ctrl_r[sdi_pkg::C_FAIL])
        |=> lamps_o.sync_green && !lamps_o.sync_red)
        else $error("synced lamp not steady green");
    flash_gate_a: assert property (
        (ce_i && !ctrl_r[sdi_pkg::C_SYNCED] && !sync_flash)
        |=> !lamps_o.sync_green)
        else $error("sync lamp lit without enable and sources");
    relay_lamp_a: assert property (
        util_relay_o == lamps_o.util_avail &&
        gen_relay_o == lamps_o.genset_avail)
        else $error("relay differs from lamp");
    ack_pulse_a: assert property (
        ack_r |=> !ack_r)
        else $error("ack held over two cycles");
endmodule
`default_nettype wire

// ### sdi_panel_op.sv
// operator model: fault reset switch held for a set time
`default_nettype none
module sdi_panel_op (
    // clock
    input wire logic clk_i,
    // switch pin
    output logic sw_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // switch rests released
    initial sw_o = 1'b0;
    // press, hold n cycles, release, then settle
    task automatic press(input int n);
        @(posedge clk_i);
        sw_o <= 1'b1;
        repeat (n) @(posedge clk_i);
        sw_o <= 1'b0;
        repeat (40) @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

// ### tb_status_diagnostic_indicator.sv
// self-checking bench of the status indicator block
`default_nettype none
module tb_status_diagnostic_indicator;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TC = 4;
    logic clk_i, rst_i, cyc, stb, we, ack, irq, en, sw, ur, gr, sok, ce;
    logic [3:0] sel;
    logic [7:0] adr, ls;
    logic [31:0] dat, rd, q;
    sdi_pkg::sdi_lamps_t lp;
    sdi_pkg::sdi_disp_t dd;
    int mismatches, checks;
    // design with short ticks, operator on the switch
    sdi_status_indicator #(.TICK_CYC(TC)) u_dut (.clk_i(clk_i),
        .rst_i(rst_i), .ce_i(ce), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(rd), .ack_o(ack),
        .irq_o(irq), .fault_reset_switch_in(sw), .sync_enable_in(en),
        .lamps_o(lp), .state_digit_display(dd), .util_relay_o(ur),
        .gen_relay_o(gr), .sync_ok_o(sok), .low_side_o(ls));
    sdi_panel_op u_op (.clk_i(clk_i), .sw_o(sw));
    // ****************
    // shared tasks
    // ****************
    task automatic chk(input string s, input logic [31:0] g, e);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // single wishbone cycle, read data left in q
    task automatic wb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rd;
        {cyc, stb} <= 2'b00;
        if (ack !== 1'b1) begin
            mismatches++;
            end_of_test();
        end
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic t_state();
        logic [6:0] gl [5];
        logic hb;
        gl = '{sdi_pkg::G_DASH, sdi_pkg::G_SIX, sdi_pkg::G_SEVEN,
            sdi_pkg::G_C, sdi_pkg::G_J};
        chk("disp", 32'(dd), 32'h0000_0040);
        for (int i = 0; i < 5; i++) begin
            wb(1'b1, sdi_pkg::A_CTRL, 32'(i << 8) | 32'h0000_0043);
            repeat (3) @(posedge clk_i);
            chk("glyph", 32'(dd), 32'(gl[i]));
        end
        chk("lamps", 32'(lp[6:3]), 32'h0000_000E);
        chk("relays", 32'({ur, gr, sok}), 32'h0000_0007);
        wb(1'b1, sdi_pkg::A_CTRL, 32'h0000_0004);
        repeat (3) @(posedge clk_i);
        chk("auto", 32'({lp[6:3], ur, gr, sok}), 32'h0000_0000);
        // byte lane 1 only
        sel <= 4'h2;
        wb(1'b1, sdi_pkg::A_CTRL, 32'hFFFF_FFFF);
        sel <= 4'hF;
        wb(1'b0, sdi_pkg::A_CTRL, 0);
        chk("sel", q, 32'h0000_FF04);
        wb(1'b0, 8'h20, 0);
        chk("unmapped", q, 0);
        // clock enable low freezes the heartbeat
        ce <= 1'b0;
        @(posedge clk_i);
        hb = lp.heartbeat;
        repeat (300) @(posedge clk_i);
        chk("freeze", lp.heartbeat, hb);
        ce <= 1'b1;
    endtask
    task automatic t_warn();
        wb(1'b1, sdi_pkg::A_IMASK, 0);
        wb(1'b1, sdi_pkg::A_LSMAP, 32'h0000_0003);
        wb(1'b1, sdi_pkg::A_WCOND, 32'h0000_0005);
        wb(1'b1, sdi_pkg::A_WCOND, 32'h0000_0004);
        chk("masked", irq, 0);
        wb(1'b1, sdi_pkg::A_IMASK, 32'h0000_000F);
        chk("irq", irq, 1);
        wb(1'b0, sdi_pkg::A_WLATCH, 0);
        chk("latch", q, 32'h0000_0005);
        chk("lowside", 32'(ls), 32'h0000_0001);
        chk("warnlamp", lp.common_warning, 1);
        wb(1'b0, sdi_pkg::A_ISTAT, 0);
        chk("istat", q, 32'h0000_0008);
        repeat (2) @(posedge clk_i);
        chk("irqclr", irq, 0);
        u_op.press(100);
        wb(1'b0, sdi_pkg::A_WLATCH, 0);
        chk("cleared", q, 32'h0000_0004);
    endtask
    // green high-cycle class 0 off, 1 blink, 2 steady over 400 cycles
    task automatic t_lamp(input logic [31:0] c, input logic e,
        input logic [1:0] xg, input logic xr);
        int g;
        int h;
        g = 0;
        h = 0;
        en <= e;
        wb(1'b1, sdi_pkg::A_CTRL, c);
        repeat (5) @(posedge clk_i);
        repeat (400) begin
            @(posedge clk_i);
            g += int'(lp.sync_green === 1'b1);
            h += int'(lp.heartbeat === 1'b1);
        end
        chk("sync", (g == 0) ? 0 : (g == 400) ? 2 : 1, 32'(xg));
        chk("red", lp.sync_red, xr);
        chk("beat", h > 0 && h < 400, 1);
    endtask
    // two-digit code: each digit lit FLASH_T ticks per repetition
    task automatic t_diag();
        int n1;
        int n2;
        n1 = 0;
        n2 = 0;
        wb(1'b1, sdi_pkg::A_FCODE, 32'h0001_0021);
        u_op.press(1900);
        chk("early", dd.dp, 0);
        u_op.press(2100);
        chk("dpon", dd.dp, 1);
        repeat (TC * (2 * sdi_pkg::FLASH_T + sdi_pkg::GAP_T
            + sdi_pkg::PAUSE_T)) begin
            @(posedge clk_i);
            n1 += int'(dd.seg === 7'h06 && dd.dp === 1'b1);
            n2 += int'(dd.seg === 7'h5B && dd.dp === 1'b1);
        end
        chk("digit1", n1, TC * sdi_pkg::FLASH_T);
        chk("digit2", n2, TC * sdi_pkg::FLASH_T);
        u_op.press(2100);
        chk("dpoff", dd.dp, 0);
    endtask
    // clock
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    // reset, scenarios, verdict
    initial begin
        {rst_i, cyc, stb, we, en, adr, dat} = {5'b10000, 40'h0};
        ce = 1'b1;
        sel = 4'hF;
        mismatches = 0;
        checks = 0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        t_state();
        t_warn();
        t_lamp(32'h0000_000F, 1'b1, 2'd1, 1'b0);
        t_lamp(32'h0000_000F, 1'b0, 2'd0, 1'b0);
        t_lamp(32'h0000_0017, 1'b1, 2'd2, 1'b0);
        t_lamp(32'h0000_0027, 1'b1, 2'd0, 1'b1);
        t_diag();
        end_of_test();
    end
endmodule
`default_nettype wire
